// File: common/ifvt_pkg.sv
/*
 Package for the interrupt flag, vector and trap block: register offsets,
 field layouts, reset values, vector table constants and the trap states.
 Assumes an APB slave with 32-bit data; 16-bit registers sit in the low bits.
*/
package ifvt_pkg;
  localparam int unsigned ADDR_W = 8;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFF_FLAGS_LOW  = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_FLAGS_HIGH = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_SER_PRIO   = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_RESET_CAUSE = 8'h0C;
  localparam logic [ADDR_W-1:0] OFF_IRQ_STATUS = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_IRQ_MASK   = 8'h14;
  localparam logic [ADDR_W-1:0] OFF_VEC_SELECT = 8'h18;
  localparam logic [ADDR_W-1:0] OFF_VEC_INFO   = 8'h1C;

  // Implemented bits of the flag and priority registers
  localparam logic [15:0] FLAGS_LOW_MASK  = 16'h3FEF;
  localparam logic [15:0] FLAGS_HIGH_MASK = 16'h20DB;
  localparam logic [15:0] SER_PRIO_MASK   = 16'h0070;
  localparam int unsigned SER_PRIO_LSB    = 4;
  localparam logic [2:0]  SER_PRIO_RESET  = 3'h4;
  localparam int unsigned TRAP_FLAG_BIT   = 15;

  // Vector mapping
  localparam int unsigned NUM_IRQ      = 46;
  localparam logic [7:0]  VEC_OFFSET   = 8'h08;
  localparam logic [23:0] PRIMARY_BASE = 24'h000014;
  localparam logic [23:0] ALT_BASE     = 24'h000114;

  // Hard trap levels
  localparam logic [3:0] HARD_TRAP_MIN   = 4'hD;
  localparam logic [3:0] ADDR_ERR_LEVEL  = 4'hD;
  localparam logic [3:0] OSC_FAIL_LEVEL  = 4'hE;

  // Interrupt status bits of this block
  localparam int unsigned EV_CONFLICT = 0;
  localparam int unsigned EV_FLAG_SET = 1;
  localparam int unsigned EV_W = 2;

  typedef enum logic [1:0] {
    IFVT_TRAP_IDLE   = 2'b00,
    IFVT_TRAP_ACTIVE = 2'b01,
    IFVT_TRAP_RESET  = 2'b11
  } ifvt_trap_state_t;

  typedef struct packed {
    logic [ADDR_W-1:0] paddr;
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [31:0]       pwdata;
  } ifvt_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } ifvt_apb_rsp_t;

  typedef struct packed {
    logic [7:0]  vector;
    logic [23:0] primary_addr;
    logic [23:0] alt_addr;
  } ifvt_vector_t;
endpackage

// File: verilog/ifvt_core.sv
/*
 Interrupt flag registers, fixed request to vector mapping, serial error
 priority field and hard trap conflict detection with its reset flag.
 Assumes request inputs and trap inputs are synchronous one-cycle pulses or
 levels on i_clk, and an APB master on the register port.
*/
// Added by the designer: the address map and the APB register port.
`timescale 1ns/1ps
module ifvt_core #(
  parameter int unsigned NUM_IRQ_P = ifvt_pkg::NUM_IRQ
) (
  input  wire logic                   i_clk,
  input  wire logic                   i_rst,
  input  wire ifvt_pkg::ifvt_apb_req_t i_apb,
  output ifvt_pkg::ifvt_apb_rsp_t     o_apb,
  input  wire logic [NUM_IRQ_P-1:0]   i_irq_req,
  input  wire logic                   i_trap_req,
  input  wire logic [3:0]             i_trap_level,
  input  wire logic                   i_trap_done,
  output logic                        o_conflict_reset,
  output logic [2:0]                  o_serial_err_prio,
  output logic                        o_serial_err_enabled,
  output logic                        o_irq
);
  import ifvt_pkg::*;

  logic [15:0]       flags_low_reg;
  logic [15:0]       flags_high_reg;
  logic [2:0]        ser_prio_reg;
  logic              trap_flag_reg;
  logic [EV_W-1:0]   ev_status_reg;
  logic [EV_W-1:0]   ev_mask_reg;
  logic [5:0]        vec_sel_reg;
  logic [3:0]        trap_level_reg;
  ifvt_trap_state_t  trap_state_reg;
  ifvt_trap_state_t  trap_state_next;
  logic [15:0]       set_low;
  logic [15:0]       set_high;
  logic              wr_en;
  logic              rd_en;
  logic              conflict;
  logic              hard_trap;
  logic [31:0]       rdata_next;
  logic [31:0]       prdata_reg;
  ifvt_vector_t      vec_info;

  function automatic ifvt_vector_t map_irq(input logic [5:0] n);
    ifvt_vector_t v;
    v.vector       = VEC_OFFSET + {2'b00, n};
    v.primary_addr = PRIMARY_BASE + {17'h00000, n, 1'b0};
    v.alt_addr     = ALT_BASE + {17'h00000, n, 1'b0};
    return v;
  endfunction

  function automatic logic hit(input logic [ADDR_W-1:0] off);
    return i_apb.paddr == off;
  endfunction

  // Zero wait-state slave; writes land in the access phase
  assign wr_en = i_apb.psel & i_apb.penable & i_apb.pwrite;
  assign rd_en = i_apb.psel & ~i_apb.penable & ~i_apb.pwrite;

  // Source requests routed to flag positions; reserved requests drop out
  always_comb begin
    set_low  = 16'h0000;
    set_high = 16'h0000;
    set_low[0]   = i_irq_req[0];
    set_low[1]   = i_irq_req[1];
    set_low[2]   = i_irq_req[2];
    set_low[3]   = i_irq_req[3];
    set_low[5]   = i_irq_req[5];
    set_low[6]   = i_irq_req[6];
    set_low[7]   = i_irq_req[7];
    set_low[8]   = i_irq_req[8];
    set_low[9]   = i_irq_req[9];
    set_low[10]  = i_irq_req[10];
    set_low[11]  = i_irq_req[11];
    set_low[12]  = i_irq_req[12];
    set_low[13]  = i_irq_req[13];
    set_high[0]  = i_irq_req[16];
    set_high[1]  = i_irq_req[17];
    set_high[3]  = i_irq_req[19];
    set_high[4]  = i_irq_req[20];
    set_high[6]  = i_irq_req[22];
    set_high[7]  = i_irq_req[23];
    set_high[13] = i_irq_req[29];
  end

  // Flags: a request in the same cycle as a software clear wins
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      flags_low_reg  <= 16'h0000;
      flags_high_reg <= 16'h0000;
    end else begin
      if (wr_en && hit(OFF_FLAGS_LOW)) begin
        flags_low_reg <= (i_apb.pwdata[15:0] | set_low) & FLAGS_LOW_MASK;
      end else begin
        flags_low_reg <= flags_low_reg | (set_low & FLAGS_LOW_MASK);
      end
      if (wr_en && hit(OFF_FLAGS_HIGH)) begin
        flags_high_reg <= (i_apb.pwdata[15:0] | set_high) & FLAGS_HIGH_MASK;
      end else begin
        flags_high_reg <= flags_high_reg | (set_high & FLAGS_HIGH_MASK);
      end
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      ser_prio_reg <= SER_PRIO_RESET;
    end else if (wr_en && hit(OFF_SER_PRIO)) begin
      ser_prio_reg <= i_apb.pwdata[SER_PRIO_LSB +: 3];
    end
  end

  assign o_serial_err_prio    = ser_prio_reg;
  assign o_serial_err_enabled = |ser_prio_reg;

  // Hard trap tracking; only levels 13..15 count
  assign hard_trap = i_trap_req && (i_trap_level >= HARD_TRAP_MIN);
  assign conflict  = hard_trap && (trap_state_reg == IFVT_TRAP_ACTIVE) &&
                     (i_trap_level < trap_level_reg);

  always_comb begin
    case (trap_state_reg)
      IFVT_TRAP_IDLE:   trap_state_next = hard_trap ? IFVT_TRAP_ACTIVE : IFVT_TRAP_IDLE;
      IFVT_TRAP_ACTIVE: begin
        if (conflict) begin
          trap_state_next = IFVT_TRAP_RESET;
        end else if (i_trap_done) begin
          trap_state_next = IFVT_TRAP_IDLE;
        end else begin
          trap_state_next = IFVT_TRAP_ACTIVE;
        end
      end
      IFVT_TRAP_RESET:  trap_state_next = IFVT_TRAP_IDLE;
      default:          trap_state_next = IFVT_TRAP_IDLE;
    endcase
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      trap_state_reg <= IFVT_TRAP_IDLE;
      trap_level_reg <= 4'h0;
    end else begin
      trap_state_reg <= trap_state_next;
      if (trap_state_reg == IFVT_TRAP_IDLE && hard_trap) begin
        trap_level_reg <= i_trap_level;
      end
    end
  end

  // One-cycle device reset request out of the conflict state
  assign o_conflict_reset = (trap_state_reg == IFVT_TRAP_RESET);

  // Cause flag survives the conflict reset it records; set beats clear
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      trap_flag_reg <= 1'b0;
    end else if (conflict) begin
      trap_flag_reg <= 1'b1;
    end else if (wr_en && hit(OFF_RESET_CAUSE)) begin
      trap_flag_reg <= i_apb.pwdata[TRAP_FLAG_BIT];
    end
  end

  // Block events: sticky, write one to clear, set wins
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      ev_status_reg <= '0;
    end else begin
      for (int i = 0; i < EV_W; i++) begin
        if ((i == EV_CONFLICT && conflict) ||
            (i == EV_FLAG_SET && (|set_low || |set_high))) begin
          ev_status_reg[i] <= 1'b1;
        end else if (wr_en && hit(OFF_IRQ_STATUS) && i_apb.pwdata[i]) begin
          ev_status_reg[i] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      ev_mask_reg <= '0;
      vec_sel_reg <= 6'h00;
    end else begin
      if (wr_en && hit(OFF_IRQ_MASK)) begin
        ev_mask_reg <= i_apb.pwdata[EV_W-1:0];
      end
      if (wr_en && hit(OFF_VEC_SELECT)) begin
        vec_sel_reg <= i_apb.pwdata[5:0];
      end
    end
  end

  assign o_irq    = |(ev_status_reg & ev_mask_reg);
  assign vec_info = map_irq(vec_sel_reg);

  // Read mux; out-of-range selection reads as zero
  always_comb begin
    rdata_next = 32'h00000000;
    case (i_apb.paddr)
      OFF_FLAGS_LOW:   rdata_next = {16'h0000, flags_low_reg};
      OFF_FLAGS_HIGH:  rdata_next = {16'h0000, flags_high_reg};
      OFF_SER_PRIO:    rdata_next = {25'h0000000, ser_prio_reg, 4'h0};
      OFF_RESET_CAUSE: rdata_next = {16'h0000, trap_flag_reg, 15'h0000};
      OFF_IRQ_STATUS:  rdata_next = {30'h00000000, ev_status_reg};
      OFF_IRQ_MASK:    rdata_next = {30'h00000000, ev_mask_reg};
      OFF_VEC_SELECT:  rdata_next = {26'h0000000, vec_sel_reg};
      OFF_VEC_INFO: begin
        if (32'(vec_sel_reg) < NUM_IRQ_P) begin
          rdata_next = {vec_info.vector, vec_info.primary_addr};
        end
      end
      default:         rdata_next = 32'h00000000;
    endcase
  end

  // Read data kept in its own register so the response struct has one driver
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      prdata_reg <= 32'h00000000;
    end else if (rd_en) begin
      prdata_reg <= rdata_next;
    end
  end

  assign o_apb.prdata  = prdata_reg;
  assign o_apb.pready  = 1'b1;
  assign o_apb.pslverr = i_apb.psel & i_apb.penable &
                         (i_apb.paddr[1:0] != 2'b00 || i_apb.paddr > OFF_VEC_INFO);
endmodule // ifvt_core

// File: sim/ifvt_src_model.sv
/*
 Partner model: peripheral request sources and the CPU trap source.
 Assumes the testbench calls its tasks; outputs change after rising edges.
*/
`timescale 1ns/1ps
module ifvt_src_model (
  input  wire logic        i_clk,
  output logic [45:0]      o_irq_req,
  output logic             o_trap_req,
  output logic [3:0]       o_trap_level,
  output logic             o_trap_done
);
  initial begin
    o_irq_req = '0;
    o_trap_req = 1'b0;
    o_trap_level = 4'h0;
    o_trap_done = 1'b0;
  end
  // One-cycle request pulse on line n
  task automatic pulse_irq(input int n);
    @(posedge i_clk);
    o_irq_req[n] <= 1'b1;
    @(posedge i_clk);
    o_irq_req <= '0;
  endtask
  // Level is only valid with the pulse; inverted after so stale values show
  task automatic trap(input logic [3:0] l);
    @(posedge i_clk);
    o_trap_req <= 1'b1;
    o_trap_level <= l;
    @(posedge i_clk);
    o_trap_req <= 1'b0;
    o_trap_level <= ~l;
  endtask
  task automatic done;
    @(posedge i_clk);
    o_trap_done <= 1'b1;
    @(posedge i_clk);
    o_trap_done <= 1'b0;
  endtask
endmodule // ifvt_src_model

// File: sim/ifvt_core_sva.sv
/*
 Checker for the interrupt flag, vector and trap block, bound to ifvt_core.
 Assumes traps are followed by a done before any further trap after a conflict.
*/
`timescale 1ns/1ps
module ifvt_core_sva import ifvt_pkg::*; #(
  parameter int unsigned NUM_IRQ_P = NUM_IRQ
) (
  input wire logic                    i_clk,
  input wire logic                    i_rst,
  input wire ifvt_pkg::ifvt_apb_req_t i_apb,
  input wire ifvt_pkg::ifvt_apb_rsp_t o_apb,
  input wire logic [NUM_IRQ_P-1:0]    i_irq_req,
  input wire logic                    i_trap_req,
  input wire logic [3:0]              i_trap_level,
  input wire logic                    i_trap_done,
  input wire logic                    o_conflict_reset,
  input wire logic [2:0]              o_serial_err_prio,
  input wire logic                    o_serial_err_enabled,
  input wire logic                    o_irq
);
  logic       act_reg;
  logic [3:0] lvl_reg;
  wire logic acc = i_apb.psel && i_apb.penable;
  wire logic rd_low = acc && !i_apb.pwrite && i_apb.paddr == OFF_FLAGS_LOW;
  wire logic rd_prio = acc && !i_apb.pwrite && i_apb.paddr == OFF_SER_PRIO;
  wire logic wr_prio = acc && i_apb.pwrite && i_apb.paddr == OFF_SER_PRIO;
  wire logic hard = i_trap_req && i_trap_level >= HARD_TRAP_MIN;
  wire logic cause = act_reg && hard && i_trap_level < lvl_reg;
  // Shadow of the trap being handled
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      act_reg <= 1'b0;
      lvl_reg <= 4'h0;
    end else if (cause || i_trap_done) begin
      act_reg <= 1'b0;
    end else if (hard && !act_reg) begin
      act_reg <= 1'b1;
      lvl_reg <= i_trap_level;
    end
  end
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  prio_enable_a: assert property (o_serial_err_enabled == (o_serial_err_prio != 3'h0))
    else $error("enable does not follow priority");
  prio_reset_a: assert property ($fell(i_rst) |-> o_serial_err_prio == SER_PRIO_RESET)
    else $error("priority reset value wrong");
  prio_write_a: assert property (wr_prio |=> o_serial_err_prio == $past(i_apb.pwdata[6:4]))
    else $error("priority write lost");
  conflict_cause_a: assert property (cause |=> o_conflict_reset)
    else $error("conflict reset missing");
  conflict_only_a: assert property (o_conflict_reset |-> $past(cause))
    else $error("conflict reset without cause");
  conflict_pulse_a: assert property (o_conflict_reset |=> !o_conflict_reset)
    else $error("conflict reset too long");
  unimp_low_a: assert property (rd_low |-> (o_apb.prdata & ~{16'h0, FLAGS_LOW_MASK}) == 32'h0)
    else $error("unused low flag bit reads one");
  unimp_prio_a: assert property (rd_prio |-> (o_apb.prdata & ~{16'h0, SER_PRIO_MASK}) == 32'h0)
    else $error("unused priority bit reads one");
  cover property (o_conflict_reset);
  cover property (wr_prio && i_apb.pwdata[6:4] == 3'h0);
  cover property (acc && o_apb.pslverr);
endmodule // ifvt_core_sva
bind ifvt_core ifvt_core_sva #(.NUM_IRQ_P(NUM_IRQ_P)) i_sva (.i_clk(i_clk), .i_rst(i_rst),
  .i_apb(i_apb), .o_apb(o_apb), .i_irq_req(i_irq_req), .i_trap_req(i_trap_req),
  .i_trap_level(i_trap_level), .i_trap_done(i_trap_done), .o_conflict_reset(o_conflict_reset),
  .o_serial_err_prio(o_serial_err_prio), .o_serial_err_enabled(o_serial_err_enabled),
  .o_irq(o_irq));

// File: sim/testbench.sv
/*
 Self-checking bench: APB master, read results matched from a queue.
 Assumes zero or short wait states; every wait is bounded.
*/
`timescale 1ns/1ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin failures++; \
  $display("ERROR t=%0t got %h exp %h", $time, a, b); end end
module testbench;
  import ifvt_pkg::*;
  logic clk, rst, trap_req, trap_done, conf, irq, prio_en;
  logic [3:0] trap_lvl;
  logic [2:0] prio;
  logic [45:0] irq_req;
  ifvt_apb_req_t req;
  ifvt_apb_rsp_t rsp;
  int failures, cmp_count, conf_n, seed, n;
  logic [31:0] expq[$];
  logic [31:0] e, fx;
  ifvt_core i_dut (.i_clk(clk), .i_rst(rst), .i_apb(req), .o_apb(rsp), .i_irq_req(irq_req),
    .i_trap_req(trap_req), .i_trap_level(trap_lvl), .i_trap_done(trap_done),
    .o_conflict_reset(conf), .o_serial_err_prio(prio), .o_serial_err_enabled(prio_en),
    .o_irq(irq));
  ifvt_src_model i_src (.i_clk(clk), .o_irq_req(irq_req), .o_trap_req(trap_req),
    .o_trap_level(trap_lvl), .o_trap_done(trap_done));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge clk);
    req <= '{paddr: a, psel: 1'b1, penable: 1'b0, pwrite: w, pwdata: d};
    @(posedge clk);
    req.penable <= 1'b1;
    for (k = 0; k < 20; k++) begin
      @(posedge clk);
      if (rsp.pready === 1'b1) break;
    end
    if (k == 20) begin
      failures++;
      wrap_up();
    end else begin
      `CHK(rsp.pslverr, (a[1:0] != 2'b00 || a > OFF_VEC_INFO))
      req.psel <= 1'b0;
      req.penable <= 1'b0;
      #1;
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    expq.push_back(x);
    apb(1'b0, a, 32'h0);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic chk_irq(input logic x);
    repeat (2) @(posedge clk);
    #1;
    `CHK(irq, x)
  endtask
  // Request k sets bit k of {high, low}; reserved lines set nothing
  function automatic logic [31:0] flag_of(input int k);
    return ((k < 14 && k != 4) || k inside {16, 17, 19, 20, 22, 23, 29}) ? 32'h1 << k : 32'h0;
  endfunction
  // Result watcher: reads complete at the sampling edge of the access phase
  always @(posedge clk) begin
    if (req.psel && req.penable && !req.pwrite && rsp.pready === 1'b1) begin
      e = expq.pop_front();
      `CHK(rsp.prdata, e)
    end
    if (conf === 1'b1) conf_n++;
  end
  initial begin
    seed = 87517;
    rst = 1'b1;
    req = '0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    rd(OFF_FLAGS_LOW, 32'h0);
    rd(OFF_SER_PRIO, 32'h40);
    rd(8'h20, 32'h0);
    wr(OFF_FLAGS_LOW, 32'hFFFFFFFF);
    wr(OFF_FLAGS_HIGH, 32'hFFFFFFFF);
    rd(OFF_FLAGS_LOW, {16'h0, FLAGS_LOW_MASK});
    rd(OFF_FLAGS_HIGH, {16'h0, FLAGS_HIGH_MASK});
    for (n = 0; n < 8; n++) begin
      wr(OFF_SER_PRIO, ($random(seed) & ~32'h70) | (n << 4));
      `CHK(prio, n[2:0])
      `CHK(prio_en, (n != 0))
      rd(OFF_SER_PRIO, n << 4);
    end
    for (int j = 0; j < 52; j++) begin
      n = (j < 46) ? j : int'($unsigned($random(seed)) % 46);
      wr(OFF_FLAGS_LOW, 32'h0);
      wr(OFF_FLAGS_HIGH, 32'h0);
      i_src.pulse_irq(n);
      fx = flag_of(n);
      rd(OFF_FLAGS_LOW, {16'h0, fx[15:0]});
      rd(OFF_FLAGS_HIGH, {16'h0, fx[31:16]});
    end
    for (n = 0; n < 47; n++) begin
      wr(OFF_VEC_SELECT, n);
      rd(OFF_VEC_INFO, n > 45 ? 32'h0 : ((n + 8) << 24) | (32'h14 + 2 * n));
    end
    rd(OFF_IRQ_STATUS, 32'h2);
    wr(OFF_IRQ_STATUS, 32'h3);
    wr(OFF_IRQ_MASK, 32'h1);
    chk_irq(1'b0);
    i_src.trap(4'hE);
    i_src.trap(4'hD);
    rd(OFF_RESET_CAUSE, 32'h8000);
    rd(OFF_IRQ_STATUS, 32'h1);
    chk_irq(1'b1);
    wr(OFF_IRQ_MASK, 32'h0);
    chk_irq(1'b0);
    wr(OFF_IRQ_MASK, 32'h1);
    wr(OFF_IRQ_STATUS, 32'h1);
    chk_irq(1'b0);
    i_src.done();
    i_src.trap(4'hD);
    i_src.trap(4'hC);
    i_src.done();
    i_src.trap(4'hD);
    i_src.trap(4'hE);
    i_src.done();
    `CHK(conf_n, 1)
    i_src.trap(4'hF);
    i_src.trap(4'hE);
    i_src.done();
    `CHK(conf_n, 2)
    wr(OFF_RESET_CAUSE, 32'h0);
    rd(OFF_RESET_CAUSE, 32'h0);
    wrap_up();
  end
endmodule // testbench
